/* File: rtc_map.vh */
`ifndef RTC_MAP_VH
`define RTC_MAP_VH
// register offsets on the i/o bus
`define RTC_SECONDS_COUNT   8'he0
`define RTC_MINUTES_COUNT   8'he1
`define RTC_HOURS_COUNT     8'he2
`define RTC_WEEKDAY_COUNT   8'he3
`define RTC_MONTH_DAY_COUNT 8'he4
`define RTC_MONTH_COUNT     8'he5
`define RTC_YEAR_COUNT      8'he6
`define RTC_CENTURY_COUNT   8'he7
`define RTC_ALARM_SECONDS   8'he8
`define RTC_ALARM_MINUTES   8'he9
`define RTC_ALARM_HOURS     8'hea
`define RTC_ALARM_WEEKDAY   8'heb
`define RTC_ALARM_CONTROL   8'hec
`define RTC_CONTROL         8'hed
// control register fields
`define RTC_CTL_ALARM_FLAG  7
`define RTC_CTL_INT_EN      6
`define RTC_CTL_BCD_EN      5
`define RTC_CTL_CLK_SEL     4
`define RTC_CTL_FREQ_SEL    3
`define RTC_CTL_UNLOCK      0
`define RTC_CTL_WR_MASK     8'h79
`define RTC_ALARM_EN_MASK   8'h0f
// count limits, binary form
`define RTC_ZERO            8'd0
`define SECONDS_COUNT_MAX         8'd59
`define RTC_MIN_MAX         8'd59
`define HOURS_COUNT_MAX         8'd23
`define RTC_WD_FIRST        8'd1
`define RTC_WD_MAX          8'd7
`define RTC_DAY_FIRST       8'd1
`define MONTH_COUNT_FIRST       8'd1
`define MONTH_COUNT_MAX         8'd12
`define RTC_YR_MAX          8'd99
// tick divider terminal counts, source edges per second
`define RTC_XTAL_DIV        16'd32768
`define RTC_LINE50_DIV      16'd50
`define RTC_LINE60_DIV      16'd60
`endif

/* File: rtc_digit_counter.v */
`timescale 1ns/1ps
// one two-digit field: binary or bcd increment with wrap
module rtc_digit_counter (
  // field value in the selected format (bcd when bcd_i), limits in binary form
  input  wire [7:0] value_i,
  input  wire [7:0] min_bin_i,
  input  wire [7:0] max_bin_i,
  input  wire       bcd_i,
  // result
  output reg  [7:0] next_value_o,
  output reg        wrap_o
);
  reg [7:0] bin;
  reg [7:0] inc;
  reg [7:0] tens;
  reg [7:0] ones;
  always @* begin
    bin = bcd_i ? ({4'h0, value_i[7:4]} * 8'd10 + {4'h0, value_i[3:0]})
                : value_i;
    wrap_o = (bin >= max_bin_i);
    inc = wrap_o ? min_bin_i : bin + 8'd1;
    tens = inc / 8'd10;
    ones = inc % 8'd10;
    // limits stay below 100, so each digit fits its nibble
    next_value_o = bcd_i ? {tens[3:0], ones[3:0]} : inc;
  end
endmodule // rtc_digit_counter

/* File: rtc_source_sync.v */
`timescale 1ns/1ps
// three-stage synchroniser on the clock source pin, rising edge out
module rtc_source_sync (
  input  wire core_clk_i,
  input  wire reset_i,
  input  wire src_pin_i,
  output reg  src_edge_o
);
  reg s1;
  reg s2;
  reg s3;
  reg level;
  always @(posedge core_clk_i) begin
    s1 <= src_pin_i;
    s2 <= s1;
    s3 <= s2;
    if (reset_i) begin
      level      <= 1'b0;
      src_edge_o <= 1'b0;
    end else begin
      src_edge_o <= 1'b0;
      if (s2 == s3 && s2 != level) begin
        level      <= s2;
        src_edge_o <= s2;
      end
    end
  end
endmodule // rtc_source_sync

/* File: rtc_calendar_alarm.v */
`timescale 1ns/1ps
`include "rtc_map.vh"
// Functional notes
// - separate counts for seconds through century; hours in 24-hour form
// - counts and alarms binary when decimal enable 0, bcd when 1
// - day-of-month wraps at true month length, february leap-adjusted
// - alarm only when every enabled set-point equals its count
// - alarm sets flag; interrupt raised only with interrupt enable
// - reading control register clears alarm flag and interrupt
// - compare alarms each time the count advances, once a second
// - any write of 0 to unlock bit forces a comparison
// - alarm set-points and alarm control writable at any time
// - tick divider from crystal or line source, chosen by selections
// - every control register write resets the tick divider
// - after reset alarm enables cleared; counts keep the values they held
// - clearing unlock resets divider then lets it run
// - unlocked stops count and allows count writes; locked counts, ignores count writes
// - unlock bit resets to 0, counter locked and running
// - seconds count keeps its value through reset
// - seconds 0..59, bcd tens 0-5, binary up to 3bh
// - minutes 0..59, bcd tens 0-5, binary up to 3bh
// - hours 0..23, bcd tens 0-2, binary up to 17h
// - weekday 1..7 in low nibble, upper nibble reads zero
// - all registers reached by i/o read and write cycles
// - day-of-month 1..31, tens 0-3, kept through reset
// - month 1..12, tens 0-1, kept through reset
module rtc_calendar_alarm (
  // clock and reset
  input  wire       core_clk_i,
  input  wire       reset_i,
  // i/o bus
  input  wire [7:0] io_addr_i,
  input  wire [7:0] io_wdata_i,
  input  wire       io_wr_i,
  input  wire       io_rd_i,
  output reg  [7:0] io_rdata_o,
  output reg        io_sel_o,
  // clock source pin: crystal or line frequency
  input  wire       rtc_src_i,
  // interrupt request to processor
  output reg        alarm_irq_o
);
  reg  [7:0] sec;
  reg  [7:0] min;
  reg  [7:0] hrs;
  reg  [3:0] weekday_field;
  reg  [7:0] mday;
  reg  [7:0] mon;
  reg  [7:0] yr;
  reg  [7:0] cen;
  reg  [7:0] alarm_val [0:3];
  reg  [3:0] alarm_en;
  reg        alarm_flag;
  reg        int_en;
  reg        bcd_en;
  reg        clk_sel;
  reg        freq_sel;
  reg        unlock;
  reg  [15:0] div_cnt;
  reg        compare_req;
  wire       src_edge;
  wire [7:0] n_sec;
  wire [7:0] n_min;
  wire [7:0] n_hrs;
  wire [7:0] n_wd;
  wire [7:0] n_mday;
  wire [7:0] n_mon;
  wire [7:0] n_yr;
  wire [7:0] n_cen;
  wire       w_sec;
  wire       w_min;
  wire       w_hrs;
  wire       w_mday;
  wire       w_mon;
  wire       w_yr;
  wire       w_wd;
  wire       w_cen;
  reg  [7:0] mon_bin;
  reg  [7:0] yr_bin;
  reg  [7:0] cen_bin;
  reg  [7:0] month_len;
  reg        leap;
  reg  [15:0] div_top;
  reg  [3:0] match;
  reg  [7:0] next_rdata;
  wire       wr_ctl;
  wire       count_wr;
  wire       tick;
  wire       alarm_hit;
  wire       int_en_next;
  wire       ctl_rd;
  wire       alarm_wr;
  wire       alarm_ctl_wr;

  rtc_source_sync u_sync (
    .core_clk_i (core_clk_i),
    .reset_i    (reset_i),
    .src_pin_i  (rtc_src_i),
    .src_edge_o (src_edge)
  );
  // calendar helpers work in binary whatever the format
  always @* begin
    mon_bin = bcd_en ? ({4'h0, mon[7:4]} * 8'd10 + {4'h0, mon[3:0]}) : mon;
    yr_bin  = bcd_en ? ({4'h0, yr[7:4]} * 8'd10 + {4'h0, yr[3:0]}) : yr;
    cen_bin = bcd_en ? ({4'h0, cen[7:4]} * 8'd10 + {4'h0, cen[3:0]}) : cen;
    // century years are leap only when the century divides by four
    leap = (yr_bin == 8'd0) ? (cen_bin[1:0] == 2'b00)
                            : (yr_bin[1:0] == 2'b00);
    case (mon_bin)
      8'd2:    month_len = leap ? 8'd29 : 8'd28;
      8'd4,
      8'd6,
      8'd9,
      8'd11:   month_len = 8'd30;
      default: month_len = 8'd31;
    endcase
  end
  // one counter slice per field, wrap feeding the next as carry
  rtc_digit_counter u_sec (
    .value_i      (sec),
    .min_bin_i    (`RTC_ZERO),
    .max_bin_i    (`SECONDS_COUNT_MAX),
    .bcd_i        (bcd_en),
    .next_value_o (n_sec),
    .wrap_o       (w_sec)
  );

  rtc_digit_counter u_min (
    .value_i      (min),
    .min_bin_i    (`RTC_ZERO),
    .max_bin_i    (`RTC_MIN_MAX),
    .bcd_i        (bcd_en),
    .next_value_o (n_min),
    .wrap_o       (w_min)
  );

  rtc_digit_counter u_hrs (
    .value_i      (hrs),
    .min_bin_i    (`RTC_ZERO),
    .max_bin_i    (`HOURS_COUNT_MAX),
    .bcd_i        (bcd_en),
    .next_value_o (n_hrs),
    .wrap_o       (w_hrs)
  );

  rtc_digit_counter u_wd (
    .value_i      ({4'h0, weekday_field}),
    .min_bin_i    (`RTC_WD_FIRST),
    .max_bin_i    (`RTC_WD_MAX),
    .bcd_i        (bcd_en),
    .next_value_o (n_wd),
    .wrap_o       (w_wd)
  );

  rtc_digit_counter u_mday (
    .value_i      (mday),
    .min_bin_i    (`RTC_DAY_FIRST),
    .max_bin_i    (month_len),
    .bcd_i        (bcd_en),
    .next_value_o (n_mday),
    .wrap_o       (w_mday)
  );

  rtc_digit_counter u_mon (
    .value_i      (mon),
    .min_bin_i    (`MONTH_COUNT_FIRST),
    .max_bin_i    (`MONTH_COUNT_MAX),
    .bcd_i        (bcd_en),
    .next_value_o (n_mon),
    .wrap_o       (w_mon)
  );

  rtc_digit_counter u_yr (
    .value_i      (yr),
    .min_bin_i    (`RTC_ZERO),
    .max_bin_i    (`RTC_YR_MAX),
    .bcd_i        (bcd_en),
    .next_value_o (n_yr),
    .wrap_o       (w_yr)
  );

  rtc_digit_counter u_cen (
    .value_i      (cen),
    .min_bin_i    (`RTC_ZERO),
    .max_bin_i    (`RTC_YR_MAX),
    .bcd_i        (bcd_en),
    .next_value_o (n_cen),
    .wrap_o       (w_cen)
  );

  assign wr_ctl   = io_wr_i && (io_addr_i == `RTC_CONTROL);
  assign count_wr = io_wr_i && unlock;
  assign tick     = !unlock && src_edge && (div_cnt == div_top - 16'd1);
  assign ctl_rd       = io_rd_i && (io_addr_i == `RTC_CONTROL);
  assign alarm_wr     = io_wr_i && (io_addr_i >= `RTC_ALARM_SECONDS)
                        && (io_addr_i <= `RTC_ALARM_WEEKDAY);
  assign alarm_ctl_wr = io_wr_i && (io_addr_i == `RTC_ALARM_CONTROL);
  // enable as it stands after this edge, so a disabling write also
  // holds back the interrupt of a hit in the same cycle
  assign int_en_next  = wr_ctl ? io_wdata_i[`RTC_CTL_INT_EN] : int_en;

  always @* begin
    if (clk_sel)
      div_top = freq_sel ? `RTC_LINE60_DIV : `RTC_LINE50_DIV;
    else
      div_top = `RTC_XTAL_DIV;
  end

  // tick divider: held while unlocked, cleared by any control write
  always @(posedge core_clk_i) begin
    if (reset_i || wr_ctl || unlock)
      div_cnt <= 16'd0;
    else if (src_edge)
      div_cnt <= tick ? 16'd0 : div_cnt + 16'd1;
  end

  // counts carry no reset so they survive it
  always @(posedge core_clk_i) begin
    if (tick) begin
      sec <= n_sec;
      if (w_sec) begin
        min <= n_min;
        if (w_min) begin
          hrs <= n_hrs;
          if (w_hrs) begin
            weekday_field <= n_wd[3:0];
            mday <= n_mday;
            if (w_mday) begin
              mon <= n_mon;
              if (w_mon) begin
                yr <= n_yr;
                if (w_yr)
                  cen <= n_cen;
              end
            end
          end
        end
      end
    end else if (count_wr) begin
      case (io_addr_i)
        `RTC_SECONDS_COUNT:   sec <= io_wdata_i;
        `RTC_MINUTES_COUNT:   min <= io_wdata_i;
        `RTC_HOURS_COUNT:     hrs <= io_wdata_i;
        `RTC_WEEKDAY_COUNT:   weekday_field <= io_wdata_i[3:0];
        `RTC_MONTH_DAY_COUNT: mday <= io_wdata_i;
        `RTC_MONTH_COUNT:     mon <= io_wdata_i;
        `RTC_YEAR_COUNT:      yr <= io_wdata_i;
        `RTC_CENTURY_COUNT:   cen <= io_wdata_i;
        default: ;
      endcase
    end
  end

  // alarm set-points: no reset, writable in any lock state
  always @(posedge core_clk_i) begin
    if (alarm_wr)
      alarm_val[io_addr_i[1:0]] <= io_wdata_i;
  end

  // compare against the counts after they settle
  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : g_match
      always @* begin
        case (g)
          0:       match[g] = (alarm_val[g] == sec);
          1:       match[g] = (alarm_val[g] == min);
          2:       match[g] = (alarm_val[g] == hrs);
          default: match[g] = (alarm_val[g][3:0] == weekday_field);
        endcase
      end
    end
  endgenerate
  assign alarm_hit = compare_req && |alarm_en
                     && ((match & alarm_en) == alarm_en);

  always @(posedge core_clk_i) begin
    if (reset_i) begin
      alarm_en    <= 4'h0;
      int_en      <= 1'b0;
      bcd_en      <= 1'b0;
      clk_sel     <= 1'b0;
      freq_sel    <= 1'b0;
      unlock      <= 1'b0;
      alarm_flag  <= 1'b0;
      alarm_irq_o <= 1'b0;
      compare_req <= 1'b0;
      io_rdata_o  <= 8'h00;
      io_sel_o    <= 1'b0;
    end else begin
      // compare one cycle after the count moves
      compare_req <= tick
                     || (wr_ctl && !io_wdata_i[`RTC_CTL_UNLOCK]);
      if (alarm_ctl_wr)
        alarm_en <= io_wdata_i[3:0];
      if (wr_ctl) begin
        int_en   <= io_wdata_i[`RTC_CTL_INT_EN];
        bcd_en   <= io_wdata_i[`RTC_CTL_BCD_EN];
        clk_sel  <= io_wdata_i[`RTC_CTL_CLK_SEL];
        freq_sel <= io_wdata_i[`RTC_CTL_FREQ_SEL];
        unlock   <= io_wdata_i[`RTC_CTL_UNLOCK];
      end
      // a new hit wins over the read that would clear it
      if (alarm_hit) begin
        alarm_flag  <= 1'b1;
        alarm_irq_o <= int_en_next;
      end else if (ctl_rd) begin
        alarm_flag  <= 1'b0;
        alarm_irq_o <= 1'b0;
      end else if (!int_en_next)
        alarm_irq_o <= 1'b0;
      io_sel_o   <= io_rd_i && io_addr_i >= `RTC_SECONDS_COUNT
                    && io_addr_i <= `RTC_CONTROL;
      io_rdata_o <= next_rdata;
    end
  end

  // read mux, one registered cycle; counts move whole on a tick
  always @* begin
    case (io_addr_i)
      `RTC_SECONDS_COUNT:   next_rdata = sec;
      `RTC_MINUTES_COUNT:   next_rdata = min;
      `RTC_HOURS_COUNT:     next_rdata = hrs;
      `RTC_WEEKDAY_COUNT:   next_rdata = {4'h0, weekday_field};
      `RTC_MONTH_DAY_COUNT: next_rdata = mday;
      `RTC_MONTH_COUNT:     next_rdata = mon;
      `RTC_YEAR_COUNT:      next_rdata = yr;
      `RTC_CENTURY_COUNT:   next_rdata = cen;
      `RTC_ALARM_SECONDS,
      `RTC_ALARM_MINUTES,
      `RTC_ALARM_HOURS,
      `RTC_ALARM_WEEKDAY:   next_rdata = alarm_val[io_addr_i[1:0]];
      `RTC_ALARM_CONTROL:   next_rdata = {4'h0, alarm_en};
      `RTC_CONTROL:         next_rdata = {alarm_flag, int_en, bcd_en,
                                          clk_sel, freq_sel, 2'b00, unlock};
      default:              next_rdata = 8'h00;
    endcase
    if (!io_rd_i)
      next_rdata = 8'h00;
  end
endmodule // rtc_calendar_alarm

/* File: rtc_calendar_alarm_assertions.sv */
`timescale 1ns/1ps
module rtc_calendar_alarm_chk (
  input wire       core_clk_i,
  input wire       reset_i,
  input wire [7:0] io_addr_i,
  input wire [7:0] io_wdata_i,
  input wire       io_wr_i,
  input wire       io_rd_i,
  input wire [7:0] io_rdata_o,
  input wire       io_sel_o,
  input wire       rtc_src_i,
  input wire       alarm_irq_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (reset_i);
  wire hit = (io_addr_i >= 8'he0) && (io_addr_i <= 8'hed);
  wire ctl = (io_addr_i == 8'hed);
  chk_sel_read: assert property (
    io_rd_i && hit |=> io_sel_o) else $error("read not selected");
  chk_bus_idle: assert property (
    !io_rd_i |=> !io_sel_o && io_rdata_o == 8'h00)
    else $error("bus not idle");
  chk_unmapped_zero: assert property (
    io_rd_i && !hit |=> !io_sel_o && io_rdata_o == 8'h00)
    else $error("unmapped read not zero");
  chk_weekday_upper: assert property (
    io_rd_i && io_addr_i == 8'he3 |=> io_rdata_o[7:4] == 4'h0)
    else $error("weekday upper bits set");
  chk_irq_clear: assert property (
    io_rd_i && ctl |=> !alarm_irq_o || !$past(alarm_irq_o))
    else $error("irq kept over control read");
  chk_irq_flag: assert property (
    io_rd_i && ctl && alarm_irq_o |=> io_rdata_o[7])
    else $error("irq without flag");
  chk_irq_enable: assert property (
    io_rd_i && ctl && alarm_irq_o |=> io_rdata_o[6])
    else $error("irq without enable");
  chk_ctl_readback: assert property (
    (io_wr_i && ctl) ##1 !io_wr_i ##1 (io_rd_i && ctl && !io_wr_i)
    |=> {1'b0, io_rdata_o[6:0]} == ($past(io_wdata_i, 3) & 8'h79))
    else $error("control readback wrong");
  chk_irq_drop: assert property (
    io_wr_i && ctl && !io_wdata_i[6] |=> !alarm_irq_o)
    else $error("irq with enable clear");
endmodule // rtc_calendar_alarm_chk

bind rtc_calendar_alarm rtc_calendar_alarm_chk u_chk (
  .core_clk_i(core_clk_i), .reset_i(reset_i), .io_addr_i(io_addr_i),
  .io_wdata_i(io_wdata_i), .io_wr_i(io_wr_i), .io_rd_i(io_rd_i),
  .io_rdata_o(io_rdata_o), .io_sel_o(io_sel_o), .rtc_src_i(rtc_src_i),
  .alarm_irq_o(alarm_irq_o));

/* File: rtc_src_model.sv */
`timescale 1ns/1ps
// free-running line source; runs through reset like the real pin
module rtc_src_model #(
  parameter int HALF = 4
) (
  input  wire  core_clk_i,
  output logic src_o
);
  int cnt = 0;
  initial src_o = 1'b0;
  always @(negedge core_clk_i) begin
    cnt <= (cnt == HALF - 1) ? 0 : cnt + 1;
    if (cnt == HALF - 1) src_o <= ~src_o;
  end
endmodule // rtc_src_model

/* File: testbench.sv */
`timescale 1ns/1ps
module testbench;
  localparam int HALF = 4;
  // 50 source periods make one second on the 50 hz line setting
  localparam int TICK = 100 * HALF;
  logic       core_clk_i;
  logic       reset_i = 1'b1;
  logic [7:0] io_addr_i = 8'h00;
  logic [7:0] io_wdata_i = 8'h00;
  logic       io_wr_i = 1'b0;
  logic       io_rd_i = 1'b0;
  wire  [7:0] io_rdata_o;
  wire        io_sel_o;
  wire        rtc_src_i;
  wire        alarm_irq_o;
  logic [7:0] d;
  logic       sel;
  int         n_mismatch = 0;
  int         checks_done = 0;

  initial begin
    core_clk_i = 1'b0;
    forever #4 core_clk_i = ~core_clk_i;
  end

  rtc_calendar_alarm u_rtc_calendar_alarm (
    .core_clk_i(core_clk_i), .reset_i(reset_i), .io_addr_i(io_addr_i),
    .io_wdata_i(io_wdata_i), .io_wr_i(io_wr_i), .io_rd_i(io_rd_i),
    .io_rdata_o(io_rdata_o), .io_sel_o(io_sel_o), .rtc_src_i(rtc_src_i),
    .alarm_irq_o(alarm_irq_o));
  rtc_src_model #(.HALF(HALF)) u_rtc_src_model (
    .core_clk_i(core_clk_i), .src_o(rtc_src_i));

  function automatic logic [7:0] enc(input int v, input bit bcd);
    return bcd ? 8'((v / 10) * 16 + v % 10) : 8'(v);
  endfunction
  function automatic int dim(input int m, input int y, input int c);
    if (m == 2) return (y % 4 == 0 && (y != 0 || c % 4 == 0)) ? 29 : 28;
    return (m == 4 || m == 6 || m == 9 || m == 11) ? 30 : 31;
  endfunction

  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(negedge core_clk_i);
    io_addr_i = a;
    io_wdata_i = v;
    io_wr_i = 1'b1;
    @(negedge core_clk_i);
    io_wr_i = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(negedge core_clk_i);
    io_addr_i = a;
    io_rd_i = 1'b1;
    @(negedge core_clk_i);
    io_rd_i = 1'b0;
    d = io_rdata_o;
    sel = io_sel_o;
  endtask
  task automatic cmp_byte(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: byte %h, want %h", $time, got, exp);
    end
  endtask
  task automatic cmp_bit(input logic got, input logic exp);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: bit %b, want %b", $time, got, exp);
    end
  endtask
  task automatic pulse_reset(input int n);
    @(negedge core_clk_i);
    reset_i = 1'b1;
    repeat (n) @(negedge core_clk_i);
    reset_i = 1'b0;
  endtask
  task automatic wait_cyc(input int n);
    repeat (n) @(negedge core_clk_i);
  endtask

  // load a whole calendar, relock and check one second later
  task automatic roll(input bit bcd, input int s, input int y);
    int e[8];
    logic [7:0] c;
    c = 8'h10 | (bcd ? 8'h20 : 8'h00);
    wr(8'hed, c | 8'h01);
    e = '{s, 59, 23, 7, 28, 2, y, 20};
    for (int i = 0; i < 8; i++) wr(8'he0 + 8'(i), enc(e[i], bcd));
    wr(8'hed, c);
    wait_cyc(TICK + 20);
    if (s < 59) e[0] = s + 1;
    else if (dim(2, y, 20) > 28) e = '{0, 0, 0, 1, 29, 2, y, 20};
    else e = '{0, 0, 0, 1, 1, 3, y, 20};
    for (int i = 0; i < 8; i++) begin
      rd(8'he0 + 8'(i));
      cmp_byte(d, enc(e[i], bcd));
    end
    wr(8'he0, 8'h2a);
    rd(8'he0);
    cmp_byte(d, enc(e[0], bcd));
    $display("test roll done");
  endtask

  task automatic print_verdict;
    $display("checks %0d, mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  initial begin
    repeat (60000) @(posedge core_clk_i);
    n_mismatch++;
    $display("unexpected at %0t: timeout", $time);
    print_verdict();
  end

  initial begin
    logic [7:0] a;
    logic [7:0] s;
    void'($urandom(93));
    wait_cyc(10);
    reset_i = 1'b0;
    rd(8'hed);
    cmp_byte(d, 8'h00);
    rd(8'hec);
    cmp_byte(d & 8'h0f, 8'h00);
    repeat (12) begin
      a = 8'($urandom);
      rd(a);
      if (a < 8'he0 || a > 8'hed) cmp_byte(d, 8'h00);
      cmp_bit(sel, a >= 8'he0 && a <= 8'hed);
    end
    $display("test reset done");
    roll(0, 59, 4);
    roll(1, 59, 5);
    roll(1, 59, 0);
    repeat (3) roll(1'($urandom), $urandom % 60, $urandom % 100);
    wr(8'hed, 8'h11);
    wr(8'he0, 8'h0a);
    wr(8'he1, 8'h05);
    wr(8'he3, 8'hf5);
    rd(8'he3);
    cmp_byte(d, 8'h05);
    wr(8'hed, 8'h10);
    wait_cyc(TICK * 3 / 5);
    wr(8'hed, 8'h10);
    wait_cyc(TICK * 3 / 5);
    rd(8'he0);
    cmp_byte(d, 8'h0a);
    wait_cyc(TICK / 2);
    rd(8'he0);
    cmp_byte(d, 8'h0b);
    // 60 hz line: no tick yet where 50 hz would have ticked
    wr(8'hed, 8'h19);
    wr(8'he0, 8'h00);
    wr(8'hed, 8'h18);
    wait_cyc(TICK + 20);
    rd(8'he0);
    cmp_byte(d, 8'h00);
    wait_cyc(TICK / 5);
    rd(8'he0);
    cmp_byte(d, 8'h01);
    $display("test divider done");
    repeat (4) begin
      s = 8'($urandom % 60);
      wr(8'he8, s);
      rd(8'he8);
      cmp_byte(d, s);
    end
    wr(8'hed, 8'h51);
    wr(8'he0, 8'h14);
    wr(8'he8, 8'h15);
    wr(8'he9, 8'h06);
    wr(8'hec, 8'h01);
    wr(8'hed, 8'h50);
    wait_cyc(TICK + 20);
    cmp_bit(alarm_irq_o, 1'b1);
    rd(8'hed);
    cmp_byte(d, 8'hd0);
    cmp_bit(alarm_irq_o, 1'b0);
    wr(8'hed, 8'h50);
    wait_cyc(4);
    cmp_bit(alarm_irq_o, 1'b1);
    wr(8'hed, 8'h10);
    wait_cyc(4);
    cmp_bit(alarm_irq_o, 1'b0);
    rd(8'hed);
    cmp_byte(d, 8'h90);
    wr(8'hec, 8'h03);
    wr(8'hed, 8'h50);
    wait_cyc(4);
    cmp_bit(alarm_irq_o, 1'b0);
    $display("test alarm done");
    rd(8'he0);
    s = d;
    wr(8'hec, 8'h0f);
    pulse_reset(3);
    rd(8'he0);
    cmp_byte(d, s);
    rd(8'hed);
    cmp_byte(d, 8'h00);
    rd(8'hec);
    cmp_byte(d & 8'h0f, 8'h00);
    $display("test rereset done");
    print_verdict();
  end
endmodule // testbench
